// ### core/rsus_pkg.sv
// Package of constants and types for the remote image upgrade sequencer
// Function
// RULE1 - Serial scheme power-up loads factory at zero
// RULE2 - Parallel scheme power-up factory address 24'h010000
// RULE3 - Boundary-scan instruction replaces parallel factory address
// RULE4 - Parallel factory address counts 16-bit words
// RULE5 - System places serial factory image at zero
// RULE6 - Only single-device configuration is supported
// RULE7 - Board straps serial or parallel scheme pins
// RULE8 - Standard mode keeps upgrade circuitry disabled
// RULE9 - Record reconfiguration cause on each error event
// RULE10 - Errors and resets reload the factory image
// RULE11 - Factory logic writes address, watchdog enable, time-out
// RULE12 - Factory logic reads cause before choosing recovery
// RULE13 - Factory logic triggers reconfiguration after writing control
// RULE14 - Successful application load enters user mode
// RULE15 - Application stores new image, then reloads factory
// RULE16 - Application image may start at any sector
// RULE17 - Provide user watchdog timer for applications
// RULE18 - Application logic restarts the watchdog periodically
// RULE19 - Boot address is image field with two zeros
// RULE20 - Watchdog count is time-out field above 17'b1000
// RULE21 - Control and status run on 10 MHz oscillator; the status register here captures on sys_clk, not on the tick
// RULE22 - Triggered reconfiguration fetches from held boot address
package rsus_pkg;

    localparam int unsigned SYS_CLK_HZ     = 40_000_000;
    localparam int unsigned OSC_HZ         = 10_000_000;
    localparam int unsigned OSC_DIV        = SYS_CLK_HZ / OSC_HZ;

    localparam logic [23:0] SERIAL_FACTORY_ADDR   = 24'h000000;
    localparam logic [23:0] PARALLEL_FACTORY_ADDR = 24'h010000;

    localparam int unsigned ADDR_FIELD_W   = 22;
    localparam int unsigned WD_FIELD_W     = 12;
    localparam int unsigned WD_COUNT_W     = 29;
    localparam logic [1:0]  ADDR_LOW_BITS  = 2'h0;
    localparam logic [16:0] WD_LOW_BITS    = 17'h00008;

    // Scheme select strap values
    localparam logic [1:0]  SCHEME_STANDARD = 2'h0;
    localparam logic [1:0]  SCHEME_SERIAL   = 2'h1;
    localparam logic [1:0]  SCHEME_PARALLEL = 2'h2;

    // Status cause bits
    localparam int unsigned CAUSE_W        = 5;
    localparam int unsigned CAUSE_FAULT    = 0;
    localparam int unsigned CAUSE_CRC      = 1;
    localparam int unsigned CAUSE_WDOG     = 2;
    localparam int unsigned CAUSE_FABRIC   = 3;
    localparam int unsigned CAUSE_PIN      = 4;

    // Image load time in oscillator ticks
    localparam int unsigned LOAD_TICKS     = 16;

    typedef enum logic [2:0] {
        RSUS_IDLE,
        RSUS_LOAD,
        RSUS_FACTORY,
        RSUS_USER
    } rsus_state_t;

    typedef enum logic [1:0] {
        RSUH_READ,
        RSUH_WRITE,
        RSUH_TRIGGER,
        RSUH_WAIT
    } rsuh_state_t;

endpackage

// ### core/rsus_if.sv
// Interface joining the upgrade sequencer and its fabric controller
`timescale 1ns/10ps
interface rsus_if;
    logic        write_en;
    logic [21:0] image_start_field;
    logic        wd_enable;
    logic [11:0] watchdog_timeout_field;
    logic        reconfig_req;
    logic        wd_restart;
    logic [4:0]  status_cause;
    logic        factory_mode;
    logic        user_mode;
    logic [23:0] boot_addr;

    modport dev  (input  write_en, image_start_field, wd_enable,
                         watchdog_timeout_field, reconfig_req, wd_restart,
                  output status_cause, factory_mode, user_mode, boot_addr);
    modport host (output write_en, image_start_field, wd_enable,
                         watchdog_timeout_field, reconfig_req, wd_restart,
                  input  status_cause, factory_mode, user_mode, boot_addr);
endinterface

// ### core/rsus_device.sv
// Dedicated upgrade sequencer: boot selection, cause capture, watchdog
`timescale 1ns/10ps
module rsus_device
    import rsus_pkg::*;
#(
    parameter int unsigned WD_COUNT_LIMIT_W = WD_COUNT_W
)(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // Board straps and pins
    input  wire logic [1:0]  scheme_select_pins,
    input  wire logic        config_fault_pin_b,
    input  wire logic        reconfig_request_pin_b,
    // Boundary-scan factory address update
    input  wire logic        parallel_factory_address_instruction,
    input  wire logic [23:0] parallel_factory_address,
    // Configuration engine
    input  wire logic        crc_error,
    input  wire logic        load_ok,
    output logic             load_start,
    output logic [23:0]      load_addr,
    // Fabric side
    rsus_if.dev              ctl
);

    rsus_state_t               state_q;
    logic [1:0]                scheme_q;
    logic                      enabled;
    logic                      osc_tick;
    logic [1:0]                div_q;
    logic [23:0]               pfactory_q;
    logic [23:0]               factory_addr;
    logic [ADDR_FIELD_W-1:0]   ctl_addr_q;
    logic                      wd_en_q;
    logic [WD_FIELD_W-1:0]     wd_field_q;
    logic [WD_COUNT_LIMIT_W-1:0] wd_cnt_q;
    logic                      fac_load_q;
    logic                      launch_d;
    logic                      launch_fac_d;
    logic [23:0]               launch_addr_d;
    logic                      wd_expire;
    logic [CAUSE_W-1:0]        cause_d;
    logic                      err_event;
    logic                      fabric_req;

    // Strap captured after reset release
    logic                      strap_done_q;
    always_ff @(posedge sys_clk or negedge rst_b)
        if (!rst_b)
        begin
            scheme_q     <= SCHEME_STANDARD;
            strap_done_q <= 1'b0;
        end
        else if (!strap_done_q)
        begin
            scheme_q     <= scheme_select_pins;
            strap_done_q <= 1'b1;
        end

    assign enabled = strap_done_q && scheme_q != SCHEME_STANDARD; // RULE8

    // 10 MHz tick from the 40 MHz clock
    always_ff @(posedge sys_clk or negedge rst_b)
        if (!rst_b)
            div_q <= 2'h0;
        else
            div_q <= div_q + 2'h1;
    assign osc_tick = (div_q == 2'(OSC_DIV - 1)); // RULE21

    // Parallel factory address, replaceable by instruction
    always_ff @(posedge sys_clk or negedge rst_b)
        if (!rst_b)
            pfactory_q <= PARALLEL_FACTORY_ADDR; // RULE2 RULE4
        else if (parallel_factory_address_instruction)
            pfactory_q <= parallel_factory_address; // RULE3

    assign factory_addr = (scheme_q == SCHEME_PARALLEL) ? pfactory_q
                        : SERIAL_FACTORY_ADDR; // RULE1

    assign fabric_req = ctl.reconfig_req && state_q == RSUS_USER;
    assign wd_expire  = wd_en_q && state_q == RSUS_USER && osc_tick &&
                        wd_cnt_q == '0;
    always_comb
    begin
        cause_d                = '0;
        cause_d[CAUSE_FAULT]   = !config_fault_pin_b;
        cause_d[CAUSE_CRC]     = crc_error;
        cause_d[CAUSE_WDOG]    = wd_expire;
        cause_d[CAUSE_FABRIC]  = fabric_req;
        cause_d[CAUSE_PIN]     = !reconfig_request_pin_b;
    end
    assign err_event = enabled && (state_q == RSUS_USER ||
                       state_q == RSUS_LOAD) && cause_d != '0;

    // Control settings written by factory image
    always_ff @(posedge sys_clk or negedge rst_b)
        if (!rst_b)
        begin
            ctl_addr_q <= '0;
            wd_en_q    <= 1'b0;
            wd_field_q <= '0;
        end
        else if (state_q == RSUS_FACTORY && ctl.write_en && osc_tick)
        begin
            ctl_addr_q <= ctl.image_start_field; // RULE16
            wd_en_q    <= ctl.wd_enable;
            wd_field_q <= ctl.watchdog_timeout_field;
        end

    // User watchdog
    always_ff @(posedge sys_clk or negedge rst_b)
        if (!rst_b)
            wd_cnt_q <= '0;
        else if (state_q != RSUS_USER || ctl.wd_restart)
            wd_cnt_q <= WD_COUNT_LIMIT_W'({wd_field_q,
                                           WD_LOW_BITS}); // RULE20 RULE18
        else if (wd_en_q && osc_tick && wd_cnt_q != '0)
            wd_cnt_q <= wd_cnt_q - 1'b1; // RULE17

    // Boot address from the control field, word aligned
    function automatic logic [23:0] boot_from_field(
        input logic [ADDR_FIELD_W-1:0] field
    );
        return {field, ADDR_LOW_BITS};
    endfunction

    // Next load: fall back on error, factory at start, chosen image on trigger
    always_comb
    begin
        launch_d      = 1'b0;
        launch_fac_d  = 1'b1;
        launch_addr_d = factory_addr;
        if (err_event)
            launch_d = 1'b1; // RULE10
        else if (state_q == RSUS_IDLE && enabled)
            launch_d = 1'b1; // RULE1 RULE2
        else if (state_q == RSUS_FACTORY && ctl.reconfig_req)
        begin
            launch_d      = 1'b1;
            launch_fac_d  = 1'b0;
            launch_addr_d = boot_from_field(ctl_addr_q); // RULE19 RULE22
        end
    end

    // One load request at a time towards the single configuration source
    always_ff @(posedge sys_clk or negedge rst_b)
        if (!rst_b)
        begin
            load_start    <= 1'b0;
            load_addr     <= '0;
            ctl.boot_addr <= '0;
            fac_load_q    <= 1'b0;
        end
        else
        begin
            load_start <= launch_d; // RULE6
            if (launch_d)
            begin
                load_addr     <= launch_addr_d;
                ctl.boot_addr <= launch_addr_d;
                fac_load_q    <= launch_fac_d;
            end
        end

    // Cause of the latest fall-back
    always_ff @(posedge sys_clk or negedge rst_b)
        if (!rst_b)
            ctl.status_cause <= '0;
        else if (err_event)
            ctl.status_cause <= cause_d; // RULE9

    // Sequencer
    always_ff @(posedge sys_clk or negedge rst_b)
        if (!rst_b)
            state_q <= RSUS_IDLE;
        else if (launch_d)
            state_q <= RSUS_LOAD;
        else
            case (state_q)
                RSUS_LOAD:
                    if (load_ok)
                        state_q <= fac_load_q ? RSUS_FACTORY : RSUS_USER;
                RSUS_IDLE, RSUS_FACTORY, RSUS_USER:
                    ;
                default:
                    state_q <= RSUS_IDLE;
            endcase

    // Mode flags follow a finished load; factory_mode means factory running
    always_ff @(posedge sys_clk or negedge rst_b)
        if (!rst_b)
        begin
            ctl.factory_mode <= 1'b0;
            ctl.user_mode    <= 1'b0;
        end
        else if (launch_d)
        begin
            ctl.factory_mode <= 1'b0;
            ctl.user_mode    <= 1'b0;
        end
        else if (state_q == RSUS_LOAD && load_ok)
        begin
            ctl.factory_mode <= fac_load_q;
            ctl.user_mode    <= !fac_load_q; // RULE14
        end

endmodule

// ### core/rsus_host.sv
// Fabric controller: reads cause, writes settings, triggers reload
`timescale 1ns/10ps
module rsus_host
    import rsus_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // User side
    input  wire logic [21:0] next_image,
    input  wire logic        next_wd_en,
    input  wire logic [11:0] next_timeout,
    input  wire logic        app_update_done,
    input  wire logic        app_alive,
    output logic [4:0]       last_cause,
    output logic             in_user_mode,
    // Sequencer side
    rsus_if.host             ctl
);

    rsuh_state_t state_q;
    logic [1:0]  hold_q;

    always_ff @(posedge sys_clk or negedge rst_b)
        if (!rst_b)
        begin
            state_q                    <= RSUH_WAIT;
            hold_q                     <= 2'h0;
            last_cause                 <= '0;
            in_user_mode               <= 1'b0;
            ctl.write_en               <= 1'b0;
            ctl.image_start_field      <= '0;
            ctl.wd_enable              <= 1'b0;
            ctl.watchdog_timeout_field <= '0;
            ctl.reconfig_req           <= 1'b0;
            ctl.wd_restart             <= 1'b0;
        end
        else
        begin
            in_user_mode   <= ctl.user_mode;
            ctl.wd_restart <= ctl.user_mode && app_alive; // RULE18
            ctl.reconfig_req <= ctl.user_mode && app_update_done; // RULE15
            case (state_q)
                RSUH_WAIT:
                    if (ctl.factory_mode && !ctl.user_mode)
                        state_q <= RSUH_READ;
                RSUH_READ:
                begin
                    last_cause <= ctl.status_cause; // RULE12
                    state_q    <= RSUH_WRITE;
                end
                RSUH_WRITE:
                begin
                    ctl.write_en               <= 1'b1; // RULE11
                    ctl.image_start_field      <= next_image;
                    ctl.wd_enable              <= next_wd_en;
                    ctl.watchdog_timeout_field <= next_timeout;
                    // Hold the settings across a full 10 MHz period
                    if (hold_q == 2'(OSC_DIV - 1))
                    begin
                        hold_q  <= 2'h0;
                        state_q <= RSUH_TRIGGER;
                    end
                    else
                        hold_q <= hold_q + 2'h1;
                end
                RSUH_TRIGGER:
                begin
                    ctl.write_en <= 1'b1;
                    // Hold the request until the factory image lets go
                    if (ctl.factory_mode)
                        ctl.reconfig_req <= 1'b1; // RULE13
                    else
                        state_q <= RSUH_WAIT;
                end
                default:
                    state_q <= RSUH_WAIT;
            endcase
            if (state_q == RSUH_WAIT)
                ctl.write_en <= 1'b0;
        end

endmodule

// ### bench/rsus_asserts.sv
// Interface checker for the upgrade sequencer and its fabric controller
`timescale 1ns/10ps
module rsus_asserts
    import rsus_pkg::*;
(
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_b,
    // Interface signals
    input wire logic        reconfig_req,
    input wire logic        wd_restart,
    input wire logic        wd_enable,
    input wire logic [21:0] image_start_field,
    input wire logic [11:0] watchdog_timeout_field,
    input wire logic [4:0]  status_cause,
    input wire logic        factory_mode,
    input wire logic        user_mode,
    input wire logic [23:0] boot_addr
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    // Cycles spent in user mode since the last watchdog restart
    logic [7:0] idle_q;
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            idle_q <= 8'h00;
        else if (!user_mode || wd_restart)
            idle_q <= 8'h00;
        else if (idle_q != 8'hFF)
            idle_q <= idle_q + 8'h01;
    end

    property p_modes_excl;
        !(factory_mode && user_mode);
    endproperty
    a_modes_excl: assert property (p_modes_excl)
        else $error("factory and user mode both set");
    property p_boot_low;
        user_mode |-> boot_addr[1:0] == 2'h0;
    endproperty
    a_boot_low: assert property (p_boot_low)
        else $error("boot address low bits not zero");
    property p_user_addr;
        $rose(user_mode) |-> boot_addr == {image_start_field, 2'h0};
    endproperty
    a_user_addr: assert property (p_user_addr)
        else $error("user image not at written address");
    property p_trigger;
        factory_mode && reconfig_req |-> ##[1:8]
            (!factory_mode && boot_addr == {image_start_field, 2'h0});
    endproperty
    a_trigger: assert property (p_trigger)
        else $error("trigger did not start the chosen image");
    property p_fall_cause;
        $fell(user_mode) |-> ##[0:2] (status_cause != 5'h00);
    endproperty
    a_fall_cause: assert property (p_fall_cause)
        else $error("user mode left without a cause");
    property p_fabric;
        $rose(reconfig_req) && user_mode |-> ##[1:4]
            status_cause[CAUSE_FABRIC];
    endproperty
    a_fabric: assert property (p_fabric)
        else $error("fabric reset not recorded");
    property p_stat;
        factory_mode && $past(factory_mode) |-> $stable(status_cause);
    endproperty
    a_stat: assert property (p_stat)
        else $error("status changed in factory image");
    property p_wd;
        user_mode && wd_enable && watchdog_timeout_field == 12'h000
            |-> idle_q <= 8'h28;
    endproperty
    a_wd: assert property (p_wd)
        else $error("watchdog did not expire in time");

    c_user: cover property ($rose(user_mode));
    c_wdog: cover property ($fell(user_mode) ##1 status_cause[CAUSE_WDOG]);
    c_trig: cover property (factory_mode && reconfig_req);
endmodule

// ### bench/rsus_bench.sv
// Testbench joining both ends of the upgrade sequencer
`timescale 1ns/10ps
module rsus_bench import rsus_pkg::*;;
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [1:0]  scheme = 2'h0;
    logic        fault_b = 1'b1;
    logic        pin_b = 1'b1;
    logic        fa_load = 1'b0;
    logic [23:0] fa_addr = 24'h000000;
    logic        crc = 1'b0;
    logic        load_ok = 1'b0;
    logic        load_start;
    logic [23:0] load_addr;
    logic [23:0] got_addr = 24'h000000;
    logic [21:0] next_image = 22'h0000A5;
    logic        next_wd_en = 1'b0;
    logic        update = 1'b0;
    logic        alive = 1'b0;
    logic [4:0]  last_cause;
    logic        in_user;
    int          fail_count = 0;
    int          n_compared = 0;
    int          n_loads = 0;
    int          cyc = 0;
    int          ld_cnt = 0;
    rsus_if      bus ();

    rsus_device rsus_device_i (.sys_clk(sys_clk), .rst_b(rst_b),
        .scheme_select_pins(scheme), .config_fault_pin_b(fault_b),
        .reconfig_request_pin_b(pin_b), .crc_error(crc),
        .parallel_factory_address_instruction(fa_load),
        .parallel_factory_address(fa_addr), .load_ok(load_ok),
        .load_start(load_start), .load_addr(load_addr), .ctl(bus.dev));
    rsus_host rsus_host_i (.sys_clk(sys_clk), .rst_b(rst_b),
        .next_image(next_image), .next_wd_en(next_wd_en),
        .next_timeout(12'h000), .app_update_done(update),
        .app_alive(alive), .last_cause(last_cause),
        .in_user_mode(in_user), .ctl(bus.host));
    rsus_asserts rsus_asserts_i (.sys_clk(sys_clk), .rst_b(rst_b),
        .reconfig_req(bus.reconfig_req), .wd_restart(bus.wd_restart),
        .wd_enable(bus.wd_enable), .image_start_field(bus.image_start_field),
        .watchdog_timeout_field(bus.watchdog_timeout_field),
        .status_cause(bus.status_cause), .factory_mode(bus.factory_mode),
        .user_mode(bus.user_mode), .boot_addr(bus.boot_addr));

    always #12.5 sys_clk = ~sys_clk;

    // Configuration engine: each load start is answered six cycles later
    always @(negedge sys_clk)
    begin
        load_ok = (ld_cnt == 1);
        if (ld_cnt != 0)
            ld_cnt = ld_cnt - 1;
        if (load_start === 1'b1)
        begin
            ld_cnt = 6;
            got_addr = load_addr;
            n_loads = n_loads + 1;
        end
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            fail_count = fail_count + 1;
            test_done();
        end
    end

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [23:0] exp,
                       input logic [23:0] got);
        n_compared = n_compared + 1;
        if (got !== exp)
        begin
            fail_count = fail_count + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wait_user(input logic want);
        int n = 0;
        while (in_user !== want && n < 400)
        begin
            @(negedge sys_clk);
            n = n + 1;
        end
        chk("user mode", {23'h0, want}, {23'h0, in_user});
    endtask

    task automatic restart(input logic [1:0] sel);
        rst_b = 1'b0;
        scheme = sel;
        repeat (8) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge sys_clk);
    endtask

    // Raise one fault event, then follow the fall-back and the relaunch
    task automatic recover(input int k, input logic [23:0] fac);
        fault_b = (k != CAUSE_FAULT);
        crc = (k == CAUSE_CRC);
        update = (k == CAUSE_FABRIC);
        pin_b = (k != CAUSE_PIN);
        repeat (2) @(negedge sys_clk);
        fault_b = 1'b1;
        crc = 1'b0;
        update = 1'b0;
        pin_b = 1'b1;
        wait_user(1'b0);
        repeat (4) @(negedge sys_clk);
        chk("factory reload", fac, got_addr);
        wait_user(1'b1);
        chk("cause", 24'h1 << k, {19'h0, last_cause});
        chk("app addr", {next_image, 2'h0}, got_addr);
    endtask

    initial
    begin
        restart(SCHEME_STANDARD);
        repeat (40) @(negedge sys_clk);
        chk("standard loads", 24'h0, n_loads[23:0]);
        restart(SCHEME_SERIAL);
        chk("serial loads", 24'h1, n_loads[23:0]);
        chk("serial factory", SERIAL_FACTORY_ADDR, got_addr);
        wait_user(1'b1);
        for (int k = 0; k < CAUSE_W; k++)
        begin
            next_wd_en = (k == CAUSE_CRC);
            next_image = next_image + 22'h000100;
            if (k == CAUSE_WDOG)
            begin
                alive = 1'b1;
                repeat (100) @(negedge sys_clk);
                chk("kept alive", 24'h1, {23'h0, in_user});
                alive = 1'b0;
            end
            recover(k, SERIAL_FACTORY_ADDR);
        end
        restart(SCHEME_PARALLEL);
        chk("parallel factory", PARALLEL_FACTORY_ADDR, got_addr);
        wait_user(1'b1);
        fa_addr = 24'h123450;
        fa_load = 1'b1;
        @(negedge sys_clk);
        fa_load = 1'b0;
        recover(CAUSE_FAULT, 24'h123450);
        test_done();
    end
endmodule
